/* rgpg_pkg.sv */
// constants and the command type for the rf gating pulse generator
package rgpg_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ       = 125;
	localparam int SYNC_LOSS_NS  = 1000;
	localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS * CLK_MHZ / 1000;
	localparam int SYNC_CNT_W    = 8;

	// ---------------------------------------------------------------
	// widths and reset values
	// ---------------------------------------------------------------
	localparam int NUM_AMP  = 8;
	localparam int DLY_W    = 8;
	localparam int FREQ_W   = 32;
	localparam int SLOT_W   = 4;
	localparam int CODE_W   = 8;
	localparam int NUM_FLT  = 11;
	localparam int FIDX_W   = 4;
	localparam logic [SLOT_W-1:0] DUAL_RX_SLOT  = 4'h0;
	localparam logic [FREQ_W-1:0] FREQ_MIN_KHZ  = 32'h0000_1388;
	localparam logic [FREQ_W-1:0] FREQ_MAX_KHZ  = 32'h0009_eb10;
	localparam logic [FREQ_W-1:0] FREQ_RST_KHZ  = 32'h0000_1388;

	// ---------------------------------------------------------------
	// fault slots, lowest index reported first
	// ---------------------------------------------------------------
	localparam int F_ESTOP = 0;
	localparam int F_PWR   = 1;
	localparam int F_PLL   = 2;
	localparam int F_SYNC  = 3;
	localparam int F_TMO   = 4;
	localparam int F_FAIL  = 5;
	localparam int F_ADDR  = 6;
	localparam int F_OBS   = 7;
	localparam int F_SLOT  = 8;
	localparam int F_FREQ  = 9;
	localparam int F_CHAN  = 10;

	localparam logic [CODE_W-1:0] CODE_SYNC  = 8'h5e;
	localparam logic [CODE_W-1:0] CODE_ADDR  = 8'h5f;
	localparam logic [CODE_W-1:0] CODE_FAIL  = 8'h62;
	localparam logic [CODE_W-1:0] CODE_TMO   = 8'h63;
	localparam logic [CODE_W-1:0] CODE_OBS   = 8'h67;
	localparam logic [CODE_W-1:0] CODE_SLOT  = 8'h6a;
	localparam logic [CODE_W-1:0] CODE_PLL   = 8'h6c;
	localparam logic [CODE_W-1:0] CODE_FREQ  = 8'h6d;
	localparam logic [CODE_W-1:0] CODE_ESTOP = 8'h6e;
	localparam logic [CODE_W-1:0] CODE_CHAN  = 8'h72;
	localparam logic [CODE_W-1:0] CODE_PWR   = 8'h74;

	// ---------------------------------------------------------------
	// commands from the board control unit
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		RGPG_CMD_OBS_BOTH,
		RGPG_CMD_FREQ,
		RGPG_CMD_DUAL_RX,
		RGPG_CMD_BOARD
	} rgpg_cmd_t;

endpackage

/* rgpg_sync3.sv */
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rgpg_sync3 #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	// ---------------------------------------------------------------
	// stages
	// ---------------------------------------------------------------
	// s1 feeds s2 only, so a metastable first stage never reaches logic
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_q  <= RST_VAL;
			s2_q  <= RST_VAL;
			s3_q  <= RST_VAL;
			out_q <= RST_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end

	assign sync_out = out_q;

endmodule // rgpg_sync3

/* rgpg_edge_shift.sv */
// gate shaper: delays the rising and falling edge of a gate by separate cycle counts
`timescale 1ns/1ps
module rgpg_edge_shift
	import rgpg_pkg::*;
(
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic             clr_in,
	input  wire logic             gate_in,
	input  wire logic [DLY_W-1:0] on_dly_in,
	input  wire logic [DLY_W-1:0] off_dly_in,
	output logic                  act_out
);

	logic             act_q;
	logic             act_d;
	logic [DLY_W-1:0] cnt_q;
	logic [DLY_W-1:0] cnt_d;
	wire              differ;
	wire  [DLY_W-1:0] lim;
	wire              fire;

	// ---------------------------------------------------------------
	// edge timing
	// ---------------------------------------------------------------
	// a gate shorter than the pending delay is swallowed, not stretched
	assign differ = gate_in != act_q;
	assign lim    = gate_in ? on_dly_in : off_dly_in;
	assign fire   = differ && (cnt_q >= lim);
	assign act_d  = fire ? gate_in : act_q;
	assign cnt_d  = (differ && !fire) ? cnt_q + 8'h01 : 8'h00;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			act_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (clr_in) begin
			act_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			act_q <= act_d;
			cnt_q <= cnt_d;
		end
	end

	assign act_out = act_q;

endmodule // rgpg_edge_shift

/* rgpg_top.sv */
// top of the rf gating pulse generator: strobes, command checks and fault latching
`timescale 1ns/1ps
module rgpg_top
	import rgpg_pkg::*;
(
	input  wire logic                sys_clk_in,
	input  wire logic                rst_in,
	input  wire logic                observe_module_in,
	input  wire logic [NUM_AMP-1:0]  tx_gate_in,
	input  wire logic [NUM_AMP-1:0]  blank_en_in,
	input  wire logic [DLY_W-1:0]    blank_lead_in,
	input  wire logic [DLY_W-1:0]    blank_trail_in,
	input  wire logic                rx_gate_in,
	input  wire logic [DLY_W-1:0]    tr_rise_dly_in,
	input  wire logic [DLY_W-1:0]    tr_fall_dly_in,
	input  wire logic [DLY_W-1:0]    rx_rise_dly_in,
	input  wire logic [DLY_W-1:0]    rx_fall_dly_in,
	input  wire logic                lo_valid_in,
	input  wire logic                adc_gate_in,
	input  wire logic                window_in,
	input  wire logic                estop_n_in,
	input  wire logic                sync20_clk_in,
	input  wire logic                pll_lock_in,
	input  wire logic                supply_ok_in,
	input  wire logic [SLOT_W-1:0]   slot_in,
	input  wire logic                multi_rx_cfg_in,
	input  wire logic                interleave_cfg_in,
	input  wire logic                cmd_valid_in,
	input  wire logic [1:0]          cmd_code_in,
	input  wire logic [FREQ_W-1:0]   cmd_freq_in,
	input  wire logic                cmd_single_addr_in,
	input  wire logic                bus_addr_err_in,
	input  wire logic                bus_cmd_fail_in,
	input  wire logic                bus_timeout_in,
	input  wire logic                fault_rd_in,
	output logic      [NUM_AMP-1:0]  amp_blank_strobe_out,
	output logic      [NUM_AMP-1:0]  amp_blank_strobe_oe_out,
	output logic                     preamp_tr_gate_n_out,
	output logic                     preamp_aux_tr_gate_n_out,
	output logic                     lo_valid_gate_n_out,
	output logic                     rx_enable_gate_n_out,
	output logic                     converter_gate_n_out,
	output logic                     dwell_window_n_out,
	output logic                     conv_capture_out,
	output logic                     conv_zero_out,
	output logic                     forced_reset_out,
	output logic                     both_observe_out,
	output logic                     dual_rx_out,
	output logic      [FREQ_W-1:0]   freq_out,
	output logic                     cmd_ack_out,
	output logic                     cmd_nak_out,
	output logic                     fault_pending_out,
	output logic                     fault_valid_out,
	output logic      [CODE_W-1:0]   fault_code_out
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [FIDX_W-1:0] rgpg_first(input logic [NUM_FLT-1:0] v);
		logic [FIDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_FLT - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = FIDX_W'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [CODE_W-1:0] rgpg_code(input logic [FIDX_W-1:0] idx);
		logic [CODE_W-1:0] c;
		case (idx)
			FIDX_W'(F_ESTOP): c = CODE_ESTOP;
			FIDX_W'(F_PWR):   c = CODE_PWR;
			FIDX_W'(F_PLL):   c = CODE_PLL;
			FIDX_W'(F_SYNC):  c = CODE_SYNC;
			FIDX_W'(F_TMO):   c = CODE_TMO;
			FIDX_W'(F_FAIL):  c = CODE_FAIL;
			FIDX_W'(F_ADDR):  c = CODE_ADDR;
			FIDX_W'(F_OBS):   c = CODE_OBS;
			FIDX_W'(F_SLOT):  c = CODE_SLOT;
			FIDX_W'(F_FREQ):  c = CODE_FREQ;
			default:          c = CODE_CHAN;
		endcase
		return c;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	wire [SLOT_W+3:0] pins_s;

	// idle levels at reset so no fault fires before the pins settle
	rgpg_sync3 #(
		.W       (SLOT_W + 4),
		.RST_VAL ({4'hf, 4'hd})
	) u_pin_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.async_in   ({slot_in, supply_ok_in, pll_lock_in, sync20_clk_in, estop_n_in}),
		.sync_out   (pins_s)
	);

	wire              estop_n_s   = pins_s[0];
	wire              sync20_s    = pins_s[1];
	wire              pll_lock_s  = pins_s[2];
	wire              supply_ok_s = pins_s[3];
	wire [SLOT_W-1:0] slot_s      = pins_s[SLOT_W+3:4];

	// ---------------------------------------------------------------
	// emergency stop
	// ---------------------------------------------------------------
	wire estop_act = !estop_n_s;

	// ---------------------------------------------------------------
	// amplifier blanking
	// ---------------------------------------------------------------
	wire [NUM_AMP-1:0] blank_act;

	// each channel blanks only when its blank_en_in bit is set, observe setting plays no part here
	for (genvar g = 0; g < NUM_AMP; g++) begin : g_blank
		rgpg_edge_shift u_blank (
			.sys_clk_in (sys_clk_in),
			.rst_in     (rst_in),
			.clr_in     (estop_act),
			.gate_in    (tx_gate_in[g] & blank_en_in[g]),
			.on_dly_in  (blank_lead_in),
			.off_dly_in (blank_trail_in),
			.act_out    (blank_act[g])
		);
	end

	// ---------------------------------------------------------------
	// receive path edge shaping
	// ---------------------------------------------------------------
	wire tr_act;
	wire rx_act;

	rgpg_edge_shift u_tr_shift (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.clr_in     (estop_act),
		.gate_in    (rx_gate_in),
		.on_dly_in  (tr_rise_dly_in),
		.off_dly_in (tr_fall_dly_in),
		.act_out    (tr_act)
	);

	rgpg_edge_shift u_rx_shift (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.clr_in     (estop_act),
		.gate_in    (rx_gate_in),
		.on_dly_in  (rx_rise_dly_in),
		.off_dly_in (rx_fall_dly_in),
		.act_out    (rx_act)
	);

	// ---------------------------------------------------------------
	// strobe decode
	// ---------------------------------------------------------------
	wire obs_ok = observe_module_in && !estop_act;
	wire tr_on  = obs_ok && tr_act;
	wire lo_on  = obs_ok && lo_valid_in;
	wire rx_on  = obs_ok && rx_act;
	wire adc_on = obs_ok && adc_gate_in;
	// window edges come straight from the sequencer, only re-timed
	wire win_on = obs_ok && window_in;

	// ---------------------------------------------------------------
	// output registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			amp_blank_strobe_oe_out <= 8'h00;
			preamp_tr_gate_n_out    <= 1'b1;
			lo_valid_gate_n_out     <= 1'b1;
			rx_enable_gate_n_out    <= 1'b1;
			converter_gate_n_out    <= 1'b1;
			dwell_window_n_out      <= 1'b1;
			conv_capture_out        <= 1'b0;
			conv_zero_out           <= 1'b0;
		end else begin
			amp_blank_strobe_oe_out <= blank_act;
			preamp_tr_gate_n_out    <= !tr_on;
			lo_valid_gate_n_out     <= !lo_on;
			rx_enable_gate_n_out    <= !rx_on;
			converter_gate_n_out    <= !adc_on;
			dwell_window_n_out      <= !win_on;
			conv_capture_out        <= win_on && adc_on;
			conv_zero_out           <= win_on && !adc_on;
		end
	end

	// open drain: data stays low, the enable alone pulls the line
	assign amp_blank_strobe_out     = 8'h00;
	// non-observe, non-lock preamp modules never see receive gating
	assign preamp_aux_tr_gate_n_out = 1'b1;
	assign forced_reset_out         = estop_act;

	// ---------------------------------------------------------------
	// command checks
	// ---------------------------------------------------------------
	wire do_cmd   = cmd_valid_in && !estop_act;
	wire is_obs   = do_cmd && (cmd_code_in == RGPG_CMD_OBS_BOTH);
	wire is_freq  = do_cmd && (cmd_code_in == RGPG_CMD_FREQ);
	wire is_dual  = do_cmd && (cmd_code_in == RGPG_CMD_DUAL_RX);
	wire is_board = do_cmd && (cmd_code_in == RGPG_CMD_BOARD);
	wire obs_bad  = is_obs && !(multi_rx_cfg_in || interleave_cfg_in);
	wire freq_bad = is_freq && ((cmd_freq_in < FREQ_MIN_KHZ) || (cmd_freq_in > FREQ_MAX_KHZ));
	wire slot_bad = is_dual && (slot_s != DUAL_RX_SLOT);
	wire chan_bad = is_board && cmd_single_addr_in;
	wire cmd_bad  = obs_bad || freq_bad || slot_bad || chan_bad;

	// the forced reset drops configuration but keeps the fault latches
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			both_observe_out <= 1'b0;
			dual_rx_out      <= 1'b0;
			freq_out         <= FREQ_RST_KHZ;
			cmd_ack_out      <= 1'b0;
			cmd_nak_out      <= 1'b0;
		end else if (estop_act) begin
			both_observe_out <= 1'b0;
			dual_rx_out      <= 1'b0;
			freq_out         <= FREQ_RST_KHZ;
			cmd_ack_out      <= 1'b0;
			cmd_nak_out      <= cmd_valid_in;
		end else begin
			if (is_obs && !obs_bad) begin
				both_observe_out <= 1'b1;
			end
			if (is_dual && !slot_bad) begin
				dual_rx_out <= 1'b1;
			end
			if (is_freq && !freq_bad) begin
				freq_out <= cmd_freq_in;
			end
			cmd_ack_out <= do_cmd && !cmd_bad;
			cmd_nak_out <= do_cmd && cmd_bad;
		end
	end

	// ---------------------------------------------------------------
	// sync clock watchdog
	// ---------------------------------------------------------------
	logic                  sync_prev_q;
	logic [SYNC_CNT_W-1:0] sync_cnt_q;
	wire                   sync_edge;
	wire                   sync_lost;

	assign sync_edge = sync20_s != sync_prev_q;
	assign sync_lost = sync_cnt_q == SYNC_CNT_W'(SYNC_LOSS_CYC);

	// saturates, so a dead clock keeps the fault asserted
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_prev_q <= 1'b0;
			sync_cnt_q  <= '0;
		end else begin
			sync_prev_q <= sync20_s;
			if (sync_edge) begin
				sync_cnt_q <= '0;
			end else if (!sync_lost) begin
				sync_cnt_q <= sync_cnt_q + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// pll lock tracking
	// ---------------------------------------------------------------
	logic lock_prev_q;
	wire  lock_lost;

	assign lock_lost = lock_prev_q && !pll_lock_s;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lock_prev_q <= 1'b1;
		end else begin
			lock_prev_q <= pll_lock_s;
		end
	end

	// ---------------------------------------------------------------
	// fault latches and readout
	// ---------------------------------------------------------------
	logic [NUM_FLT-1:0] flt_q;
	logic [NUM_FLT-1:0] flt_d;
	logic [CODE_W-1:0]  code_q;
	logic               fvalid_q;
	wire  [NUM_FLT-1:0] flt_ev;

	assign flt_ev[F_ESTOP] = estop_act;
	assign flt_ev[F_PWR]   = !supply_ok_s;
	assign flt_ev[F_PLL]   = lock_lost;
	assign flt_ev[F_SYNC]  = sync_lost;
	assign flt_ev[F_TMO]   = bus_timeout_in;
	assign flt_ev[F_FAIL]  = bus_cmd_fail_in;
	assign flt_ev[F_ADDR]  = bus_addr_err_in;
	assign flt_ev[F_OBS]   = obs_bad;
	assign flt_ev[F_SLOT]  = slot_bad;
	assign flt_ev[F_FREQ]  = freq_bad;
	assign flt_ev[F_CHAN]  = chan_bad;

	wire                rd_take = fault_rd_in && (flt_q != '0);
	wire  [FIDX_W-1:0]  flt_sel = rgpg_first(flt_q);
	wire  [NUM_FLT-1:0] flt_clr = rd_take ? (NUM_FLT'(1) << flt_sel) : '0;
	// a new event in the clearing cycle wins over the read
	assign flt_d   = (flt_q & ~flt_clr) | flt_ev;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flt_q    <= '0;
			code_q   <= 8'h00;
			fvalid_q <= 1'b0;
		end else begin
			flt_q    <= flt_d;
			fvalid_q <= rd_take;
			if (rd_take) begin
				code_q <= rgpg_code(flt_sel);
			end
		end
	end

	assign fault_pending_out = flt_q != '0;
	assign fault_valid_out   = fvalid_q;
	assign fault_code_out    = code_q;

endmodule // rgpg_top

/* rgpg_seq_model.sv */
// sequencer and backplane stand-in: 20 mhz sync clock and conversion window
`timescale 1ns/1ps
module rgpg_seq_model (
	input  wire logic       sys_clk_in,
	input  wire logic       sync_run_in,
	input  wire logic       win_go_in,
	input  wire logic [3:0] win_len_in,
	output logic            sync20_clk_out,
	output logic            window_out
);
	logic [1:0] div_q = 2'h0;
	logic [3:0] win_q = 4'h0;
	initial sync20_clk_out = 1'b0;
	// three cycles a half period; halting freezes the line, as a cut cable would
	always @(posedge sys_clk_in) begin
		div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
		if (sync_run_in && div_q == 2'h2)
			sync20_clk_out <= ~sync20_clk_out;
	end
	always @(posedge sys_clk_in) begin
		if (win_go_in)
			win_q <= win_len_in;
		else if (win_q != 4'h0)
			win_q <= win_q - 4'h1;
	end
	assign window_out = (win_q != 4'h0);
endmodule // rgpg_seq_model

/* rgpg_top_checker.sv */
// concurrent checks on the gating strobes, commands and fault readout
`timescale 1ns/1ps
module rgpg_top_checker
	import rgpg_pkg::*;
(
	input wire logic                sys_clk_in,
	input wire logic                rst_in,
	input wire logic                observe_module_in,
	input wire logic                lo_valid_in,
	input wire logic                window_in,
	input wire logic                cmd_valid_in,
	input wire logic [1:0]          cmd_code_in,
	input wire logic [FREQ_W-1:0]   cmd_freq_in,
	input wire logic                cmd_single_addr_in,
	input wire logic                fault_rd_in,
	input wire logic [NUM_AMP-1:0]  amp_blank_strobe_out,
	input wire logic                preamp_aux_tr_gate_n_out,
	input wire logic                lo_valid_gate_n_out,
	input wire logic                converter_gate_n_out,
	input wire logic                dwell_window_n_out,
	input wire logic                conv_capture_out,
	input wire logic                conv_zero_out,
	input wire logic                forced_reset_out,
	input wire logic                both_observe_out,
	input wire logic                dual_rx_out,
	input wire logic [FREQ_W-1:0]   freq_out,
	input wire logic                cmd_ack_out,
	input wire logic                cmd_nak_out,
	input wire logic                fault_pending_out,
	input wire logic                fault_valid_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire live     = observe_module_in && !forced_reset_out;
	wire freq_cmd = cmd_valid_in && !forced_reset_out && cmd_code_in == RGPG_CMD_FREQ;
	wire freq_ok  = cmd_freq_in >= FREQ_MIN_KHZ && cmd_freq_in <= FREQ_MAX_KHZ;
	wire brd_cmd  = cmd_valid_in && !forced_reset_out && cmd_code_in == RGPG_CMD_BOARD;

	a_aux_tx_hold: assert property (preamp_aux_tr_gate_n_out)
		else $error("aux preamp gate left transmit");
	a_blank_open_drain: assert property (amp_blank_strobe_out == '0)
		else $error("blank data line driven high");
	a_lo_follow: assert property (live && lo_valid_in |=> forced_reset_out || !lo_valid_gate_n_out)
		else $error("lo strobe missing");
	a_idle_off_obs: assert property (!observe_module_in |=> lo_valid_gate_n_out && dwell_window_n_out)
		else $error("strobe active off observe");
	a_window_low: assert property (live && window_in |=> forced_reset_out || !dwell_window_n_out)
		else $error("window strobe not low");
	a_capture_pair: assert property (conv_capture_out |-> !converter_gate_n_out && !dwell_window_n_out)
		else $error("capture without gate and window");
	a_zero_pair: assert property (conv_zero_out |-> converter_gate_n_out && !dwell_window_n_out)
		else $error("zero data without window");
	a_freq_accept: assert property (freq_cmd && freq_ok |=> cmd_ack_out && freq_out == $past(cmd_freq_in))
		else $error("in-range frequency not taken");
	a_freq_refuse: assert property (freq_cmd && !freq_ok |=> cmd_nak_out && !cmd_ack_out && $stable(freq_out))
		else $error("out-of-range frequency taken");
	a_board_refuse: assert property (brd_cmd && cmd_single_addr_in |=> cmd_nak_out)
		else $error("board command on single address taken");
	a_estop_clear: assert property (forced_reset_out |=> !both_observe_out && !dual_rx_out)
		else $error("config survives stop");
	a_read_answer: assert property (fault_rd_in && fault_pending_out |=> fault_valid_out)
		else $error("read of pending fault unanswered");
	a_read_empty: assert property (fault_rd_in && !fault_pending_out |=> !fault_valid_out)
		else $error("fault reported with none pending");

	c_capture: cover property (conv_capture_out);
	c_refused: cover property (cmd_nak_out);
	c_stop: cover property (forced_reset_out ##1 !forced_reset_out);
	c_fault: cover property (fault_valid_out);
endmodule // rgpg_top_checker

bind rgpg_top rgpg_top_checker u_chk (.*);

/* rgpg_top_test.sv */
// self-checking bench for the rf gating pulse generator
`timescale 1ns/1ps
module rgpg_top_test
	import rgpg_pkg::*;
;
	logic               sys_clk_in, rst_in = 1'b1, window_in, sync20_clk_in;
	logic               observe_module_in = 0, rx_gate_in = 0, lo_valid_in = 0, adc_gate_in = 0, estop_n_in = 1;
	logic               pll_lock_in = 1, supply_ok_in = 1, multi_rx_cfg_in = 0, interleave_cfg_in = 0;
	logic               cmd_valid_in = 0, cmd_single_addr_in = 0, fault_rd_in = 0, sync_run = 1, win_go = 0;
	logic               bus_addr_err_in = 0, bus_cmd_fail_in = 0, bus_timeout_in = 0;
	logic [NUM_AMP-1:0] tx_gate_in = 8'h00, blank_en_in = 8'hff, amp_blank_strobe_out, amp_blank_strobe_oe_out;
	logic [DLY_W-1:0]   blank_lead_in = 8'h02, blank_trail_in = 8'h03, tr_rise_dly_in = 8'h01;
	logic [DLY_W-1:0]   tr_fall_dly_in = 8'h00, rx_rise_dly_in = 8'h03, rx_fall_dly_in = 8'h00;
	logic [SLOT_W-1:0]  slot_in = 4'h0;
	logic [1:0]         cmd_code_in = 2'h0;
	logic [FREQ_W-1:0]  cmd_freq_in = 32'h0, freq_out;
	logic               preamp_tr_gate_n_out, preamp_aux_tr_gate_n_out, lo_valid_gate_n_out, rx_enable_gate_n_out;
	logic               converter_gate_n_out, dwell_window_n_out, conv_capture_out, conv_zero_out, forced_reset_out;
	logic               both_observe_out, dual_rx_out, cmd_ack_out, cmd_nak_out, fault_pending_out, fault_valid_out;
	logic [CODE_W-1:0]  fault_code_out;
	int                 err_total = 0, total_checks = 0;

	rgpg_top DUT (.*);
	rgpg_seq_model u_seq (.sys_clk_in(sys_clk_in), .sync_run_in(sync_run), .win_go_in(win_go),
		.win_len_in(4'h6), .sync20_clk_out(sync20_clk_in), .window_out(window_in));

	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// -------------------------------------------------------------
	// shared helpers
	// -------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	task automatic cmd(input rgpg_cmd_t code, input logic [31:0] f, input logic single, input logic ack);
		tick(1);
		cmd_valid_in = 1'b1;
		cmd_code_in = code;
		cmd_freq_in = f;
		cmd_single_addr_in = single;
		tick(1);
		cmd_valid_in = 1'b0;
		chk("ack", cmd_ack_out, ack);
		chk("nak", cmd_nak_out, !ack);
	endtask
	// one read per call; answer lands one cycle after the strobe
	task automatic rd(input logic [7:0] code);
		tick(1);
		fault_rd_in = 1'b1;
		tick(1);
		fault_rd_in = 1'b0;
		chk("fault valid", fault_valid_out, 1'b1);
		chk("fault code", fault_code_out, code);
	endtask

	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic t_reset();
		chk("idle strobes", {preamp_tr_gate_n_out, lo_valid_gate_n_out, rx_enable_gate_n_out, converter_gate_n_out,
			dwell_window_n_out}, 5'h1f);
		chk("blank idle", {amp_blank_strobe_out, amp_blank_strobe_oe_out}, 16'h0);
		chk("aux preamp", preamp_aux_tr_gate_n_out, 1'b1);
		chk("reset freq", freq_out, 32'h0000_1388);
		chk("no fault", fault_pending_out, 1'b0);
	endtask
	task automatic t_blank();
		tick(1);
		tx_gate_in = 8'h01;
		for (int k = 1; k <= 5; k++) begin
			tick(1);
			chk("blank lead", amp_blank_strobe_oe_out, {7'h0, k >= 4});
		end
		tx_gate_in = 8'h00;
		for (int k = 1; k <= 6; k++) begin
			tick(1);
			chk("blank trail", amp_blank_strobe_oe_out, {7'h0, k < 5});
		end
	endtask
	task automatic t_obs();
		tick(1);
		lo_valid_in = 1'b1;
		adc_gate_in = 1'b1;
		win_go = 1'b1;
		tick(1);
		win_go = 1'b0;
		tick(1);
		chk("lo off observe", lo_valid_gate_n_out, 1'b1);
		observe_module_in = 1'b1;
		tick(1);
		chk("lo gate", {lo_valid_gate_n_out, converter_gate_n_out}, 2'h0);
		chk("window", dwell_window_n_out, 1'b0);
		chk("capture", conv_capture_out, 1'b1);
		adc_gate_in = 1'b0;
		tick(1);
		chk("zero data", {converter_gate_n_out, conv_zero_out, conv_capture_out}, 3'h6);
		lo_valid_in = 1'b0;
		tick(5);
		chk("window closed", {dwell_window_n_out, lo_valid_gate_n_out, conv_zero_out}, 3'h6);
	endtask
	task automatic t_shape();
		rx_gate_in = 1'b1;
		for (int k = 1; k <= 5; k++) begin
			tick(1);
			chk("tr rise", preamp_tr_gate_n_out, k < 3);
			chk("rx rise", rx_enable_gate_n_out, k < 5);
		end
		rx_gate_in = 1'b0;
		for (int k = 1; k <= 2; k++) begin
			tick(1);
			chk("tr rx fall", {preamp_tr_gate_n_out, rx_enable_gate_n_out}, {2{k >= 2}});
		end
		observe_module_in = 1'b0;
		rx_gate_in = 1'b1;
		tick(6);
		chk("tr off observe", {preamp_tr_gate_n_out, rx_enable_gate_n_out}, 2'h3);
		rx_gate_in = 1'b0;
	endtask
	task automatic t_freq();
		cmd(RGPG_CMD_FREQ, 32'h0000_1388, 1'b0, 1'b1);
		cmd(RGPG_CMD_FREQ, 32'h0000_1387, 1'b0, 1'b0);
		cmd(RGPG_CMD_FREQ, 32'h0009_eb10, 1'b0, 1'b1);
		cmd(RGPG_CMD_FREQ, 32'h0009_eb11, 1'b0, 1'b0);
		chk("freq kept", freq_out, 32'h0009_eb10);
		rd(8'h6d);
		chk("drained", fault_pending_out, 1'b0);
	endtask
	task automatic t_cfg();
		cmd(RGPG_CMD_OBS_BOTH, 32'h0, 1'b0, 1'b0);
		interleave_cfg_in = 1'b1;
		cmd(RGPG_CMD_OBS_BOTH, 32'h0, 1'b0, 1'b1);
		interleave_cfg_in = 1'b0;
		multi_rx_cfg_in = 1'b1;
		cmd(RGPG_CMD_OBS_BOTH, 32'h0, 1'b0, 1'b1);
		cmd(RGPG_CMD_BOARD, 32'h0, 1'b1, 1'b0);
		cmd(RGPG_CMD_BOARD, 32'h0, 1'b0, 1'b1);
		slot_in = 4'h1;
		tick(8);
		cmd(RGPG_CMD_DUAL_RX, 32'h0, 1'b0, 1'b0);
		chk("dual refused", dual_rx_out, 1'b0);
		slot_in = 4'h0;
		tick(8);
		cmd(RGPG_CMD_DUAL_RX, 32'h0, 1'b0, 1'b1);
		chk("config", {dual_rx_out, both_observe_out}, 2'h3);
		rd(8'h67);
		rd(8'h6a);
		rd(8'h72);
		chk("drained", fault_pending_out, 1'b0);
	endtask
	task automatic t_bus();
		tick(1);
		{bus_addr_err_in, bus_cmd_fail_in, bus_timeout_in} = 3'h7;
		tick(1);
		{bus_addr_err_in, bus_cmd_fail_in, bus_timeout_in} = 3'h0;
		rd(8'h63);
		rd(8'h62);
		rd(8'h5f);
		chk("drained", fault_pending_out, 1'b0);
	endtask
	task automatic t_pins();
		pll_lock_in = 1'b0;
		tick(8);
		pll_lock_in = 1'b1;
		supply_ok_in = 1'b0;
		tick(8);
		supply_ok_in = 1'b1;
		sync_run = 1'b0;
		tick(140);
		sync_run = 1'b1;
		tick(10);
		rd(8'h74);
		rd(8'h6c);
		rd(8'h5e);
		chk("drained", fault_pending_out, 1'b0);
	endtask
	task automatic t_estop();
		observe_module_in = 1'b1;
		lo_valid_in = 1'b1;
		estop_n_in = 1'b0;
		tick(8);
		chk("stop state", {forced_reset_out, lo_valid_gate_n_out, dual_rx_out, both_observe_out}, 4'hc);
		cmd(RGPG_CMD_FREQ, 32'h0001_86a0, 1'b0, 1'b0);
		estop_n_in = 1'b1;
		tick(8);
		chk("resumed", {forced_reset_out, lo_valid_gate_n_out}, 2'h0);
		rd(8'h6e);
		chk("drained", fault_pending_out, 1'b0);
	endtask

	// -------------------------------------------------------------
	// run
	// -------------------------------------------------------------
	task automatic summarize();
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		tick(8);
		rst_in = 1'b0;
		tick(6);
		t_reset();
		t_blank();
		t_obs();
		t_shape();
		t_freq();
		t_cfg();
		t_bus();
		t_pins();
		t_estop();
		summarize();
	end
	// run needs well under a thousand cycles
	initial begin
		#100us;
		err_total++;
		summarize();
	end
endmodule // rgpg_top_test
